/* hw/sbsp_pkg.sv */
// package for the synchronous burst sram host port: widths, reset values, carriers.
// assumes a single 25 MHz clock; the memory array itself sits outside the port.
package sbsp_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int BURST_W = 2;
   localparam int WORD_W = DATA_W + LANES;
   localparam int OE_SYNC_W = 3;
   // output enable pin idles high (pins released) until sampled otherwise
   localparam logic [OE_SYNC_W-1:0] OE_SYNC_RST = 3'h7;
   localparam logic [LANES-1:0] LANES_ALL = 4'hf;
   localparam logic [LANES-1:0] LANES_NONE = 4'h0;

   // synchronous control pins as sampled at each rising edge
   typedef struct packed {
      logic processor_addr_strobe_n;
      logic controller_addr_strobe_n;
      logic burst_advance_n;
      logic byte_write_enable_n;
      logic lane_a_write_select_n;
      logic lane_b_write_select_n;
      logic lane_c_write_select_n;
      logic lane_d_write_select_n;
      logic all_lanes_write_n;
      logic select_first_n;
      logic select_second;
      logic select_third_n;
      logic [ADDR_W-1:0] addr;
   } sbsp_bus_t;

   // request toward the memory array
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic rd;
      logic [LANES-1:0] lane_we;
      logic [WORD_W-1:0] wdata;
   } sbsp_mem_req_t;
endpackage : sbsp_pkg

/* hw/sbsp_port.sv */
// host port of a pipelined burst sram: address/burst logic, write control, pin direction.
// assumes the bus master is synchronous to clk_i; only the output enable pin is asynchronous.
// the array answers mem_rdata_i combinationally for the address on mem_req_o.
`timescale 1ns/1ns
module sbsp_port #(
   parameter bit PKG_BALL_GRID = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire sbsp_pkg::sbsp_bus_t bus_i,
   input wire logic output_enable_n_i,
   input wire logic [sbsp_pkg::DATA_W-1:0] dq_i,
   input wire logic [sbsp_pkg::LANES-1:0] parity_bus_i,
   output logic [sbsp_pkg::DATA_W-1:0] dq_o,
   output logic [sbsp_pkg::LANES-1:0] parity_bus_o,
   output logic dq_oe_o,
   output sbsp_pkg::sbsp_mem_req_t mem_req_o,
   input wire logic [sbsp_pkg::WORD_W-1:0] mem_rdata_i
);
   typedef struct packed {
      logic [sbsp_pkg::ADDR_W-1:0] base;
      logic [sbsp_pkg::BURST_W-1:0] burst;
      logic sel;
      logic [sbsp_pkg::OE_SYNC_W-1:0] oe_sync;
      logic oe_n;
      logic rd;
      logic first;
      sbsp_pkg::sbsp_mem_req_t req;
      logic [sbsp_pkg::WORD_W-1:0] dq;
      logic dq_oe;
   } sbsp_state_t;

   sbsp_state_t s_q;
   sbsp_state_t s_d;
   logic p_strobe;
   logic c_strobe;
   logic load;
   logic ce_ok;
   logic wr_now;
   logic [sbsp_pkg::LANES-1:0] lanes;
   logic [sbsp_pkg::ADDR_W-1:0] cur_addr;

   // lane enables from the sampled write pins; the checks decode the pins on their own
   function automatic logic [sbsp_pkg::LANES-1:0] lane_mask(input sbsp_pkg::sbsp_bus_t b);
      if (!b.all_lanes_write_n) begin
         lane_mask = sbsp_pkg::LANES_ALL;
      end else if (!b.byte_write_enable_n) begin
         lane_mask = ~{b.lane_d_write_select_n, b.lane_c_write_select_n,
                       b.lane_b_write_select_n, b.lane_a_write_select_n};
      end else begin
         lane_mask = sbsp_pkg::LANES_NONE;
      end
   endfunction : lane_mask

   // two-bit counter: natural overflow keeps the beat inside its group of four
   function automatic logic [sbsp_pkg::BURST_W-1:0] burst_step(
         input logic [sbsp_pkg::BURST_W-1:0] c, input logic adv_n);
      burst_step = adv_n ? c : c + 2'h1;
   endfunction : burst_step

   // strobe arbitration and chip select decode
   always_comb begin
      p_strobe = !bus_i.processor_addr_strobe_n && !bus_i.select_first_n;
      c_strobe = !bus_i.controller_addr_strobe_n && !p_strobe;
      load = p_strobe || c_strobe;
      // third enable is absent on the ball-grid part
      ce_ok = !bus_i.select_first_n && bus_i.select_second &&
              (PKG_BALL_GRID || !bus_i.select_third_n);
      lanes = lane_mask(bus_i);
   end

   // next-state logic for the whole port
   always_comb begin
      s_d = s_q;
      // oe is the only asynchronous pin: three stages, accept once the last two agree
      s_d.oe_sync = {s_q.oe_sync[1:0], output_enable_n_i};
      if (s_q.oe_sync[1] == s_q.oe_sync[2]) begin
         s_d.oe_n = s_q.oe_sync[2];
      end
      cur_addr = {s_q.base[sbsp_pkg::ADDR_W-1:sbsp_pkg::BURST_W], s_q.burst};
      if (load) begin
         // enables only matter here; burst beats never look at them
         s_d.sel = ce_ok;
         if (ce_ok) begin
            s_d.base = bus_i.addr;
            s_d.burst = bus_i.addr[sbsp_pkg::BURST_W-1:0];
            cur_addr = bus_i.addr;
         end
      end else if (s_q.sel) begin
         s_d.burst = burst_step(s_q.burst, bus_i.burst_advance_n);
         cur_addr = {s_q.base[sbsp_pkg::ADDR_W-1:sbsp_pkg::BURST_W], s_d.burst};
      end
      // a processor-strobe edge always opens as a read; its write follows next clock
      wr_now = s_d.sel && !p_strobe && (lanes != sbsp_pkg::LANES_NONE);
      s_d.req.addr = cur_addr;
      s_d.req.lane_we = wr_now ? lanes : sbsp_pkg::LANES_NONE;
      s_d.req.wdata = {parity_bus_i, dq_i};
      s_d.req.rd = s_d.sel && !wr_now;
      // read beat: the array answers during the next cycle, captured at its end
      s_d.rd = s_q.req.rd;
      s_d.first = s_d.sel && !s_q.sel;
      s_d.dq = mem_rdata_i;
      // mask oe on the first beat after deselect when it is a read; release on writes and deselect
      s_d.dq_oe = s_q.req.rd && !s_q.first && !s_q.oe_n && s_q.sel;
      if (s_q.oe_n) begin
         s_d.dq_oe = 1'b0;
      end
   end

   // single state register; reset leaves the port deselected with pins released
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.oe_sync <= sbsp_pkg::OE_SYNC_RST;
         s_q.oe_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign dq_o = s_q.dq[sbsp_pkg::DATA_W-1:0];
   assign parity_bus_o = s_q.dq[sbsp_pkg::WORD_W-1:sbsp_pkg::DATA_W];
   assign dq_oe_o = s_q.dq_oe;
   assign mem_req_o = s_q.req;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // a selecting strobe captures the pin address at the very next register update
   chk_addr_load: assert property (
      (load && ce_ok) |=> (mem_req_o.addr == $past(bus_i.addr) && s_q.sel))
      else $error("address not loaded on selecting strobe");

   // low bits of the loaded address seed the counter
   chk_burst_seed: assert property (
      (load && ce_ok) |=> (s_q.burst == $past(bus_i.addr[1:0])))
      else $error("burst counter not seeded from address");

   // byte write lanes follow the selects exactly
   chk_lane_write: assert property (
      (s_q.sel && !load && bus_i.all_lanes_write_n && !bus_i.byte_write_enable_n)
      |=> (mem_req_o.lane_we == ~{$past(bus_i.lane_d_write_select_n),
           $past(bus_i.lane_c_write_select_n), $past(bus_i.lane_b_write_select_n),
           $past(bus_i.lane_a_write_select_n)}))
      else $error("byte lane write mismatch");

   // global write covers every lane
   chk_global_write: assert property (
      (s_q.sel && !load && !bus_i.all_lanes_write_n) |=> (mem_req_o.lane_we == 4'hf))
      else $error("global write missed a lane");

   // advance increments with wrap, else holds
   chk_burst_step: assert property (
      (s_q.sel && !load) |=> (s_q.burst == ($past(bus_i.burst_advance_n) ?
                              $past(s_q.burst) : $past(s_q.burst) + 2'h1)))
      else $error("burst counter step wrong");

   // processor strobe with first enable high starts nothing on its own
   chk_strobe_ignored: assert property (
      (bus_i.controller_addr_strobe_n && bus_i.select_first_n) |=>
      (s_q.sel == $past(s_q.sel) && s_q.base == $past(s_q.base)))
      else $error("ignored strobe changed selection");

   // burst beats keep selection whatever the enables do
   chk_ce_beat: assert property (
      (s_q.sel && !load) |=> s_q.sel)
      else $error("enables acted during a burst beat");

   // wrong enable pattern on a load deselects
   chk_deselect: assert property (
      (load && !bus_i.select_second) |=> !s_q.sel)
      else $error("selected with second enable low");

   // pins never drive during a write beat or while deselected
   chk_tristate: assert property (
      (mem_req_o.lane_we != 4'h0 || !s_q.sel) |=> !dq_oe_o)
      else $error("data pins driven in write or deselect");

   // a read on the first beat after deselect is masked even with oe low
   chk_first_mask: assert property (
      (mem_req_o.rd && s_q.first) |=> !dq_oe_o)
      else $error("output enable not masked after deselect");

   // oe high releases the pins within the synchroniser delay plus the output register
   chk_oe_release: assert property (
      (output_enable_n_i [*5]) |=> !dq_oe_o)
      else $error("pins driven with output enable high");
endmodule : sbsp_port

/* sim/sbsp_array_model.sv */
// behavioural memory array behind the port's request side
// assumes requests are registered on clk_i; read data returns combinationally
`timescale 1ns/1ns
module sbsp_array_model (
   input wire logic clk_i,
   input wire sbsp_pkg::sbsp_mem_req_t req_i,
   output logic [35:0] rdata_o
);
   logic [35:0] mem [logic [19:0]];
   // lane i owns data byte i and parity bit i
   always @(posedge clk_i) begin
      for (int i = 0; i < 4; i++) begin
         if (req_i.lane_we[i] === 1'b1) begin
            mem[req_i.addr][8*i+:8] = req_i.wdata[8*i+:8];
            mem[req_i.addr][32+i] = req_i.wdata[32+i];
         end
      end
   end
   // unwritten places read as zero rather than stale data
   always_comb begin
      rdata_o = mem.exists(req_i.addr) ? mem[req_i.addr] : 36'h0;
   end
endmodule : sbsp_array_model

/* sim/sbsp_port_test.sv */
// bench for sbsp_port: bus master stimulus, shadow memory, result queue
// assumes sbsp_array_model stands on the memory side
`timescale 1ns/1ns
module sbsp_port_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   sbsp_pkg::sbsp_bus_t bus_i;
   logic oe_n = 1'b0;
   logic [35:0] wd = 36'h0;
   logic [35:0] rd;
   logic [31:0] dq_o;
   logic [3:0] par_o;
   logic dq_oe_o;
   sbsp_pkg::sbsp_mem_req_t req;
   logic [35:0] sh [logic [19:0]];
   logic [35:0] exp_q [$];
   logic [25:0] nx = 26'h0;
   logic [25:0] cur = 26'h0;
   logic [19:0] hi;
   int miscompares = 0;
   int check_count = 0;
   always #20 clk_i = ~clk_i;
   sbsp_port sbsp_port_i (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i),
      .output_enable_n_i(oe_n), .dq_i(wd[31:0]), .parity_bus_i(wd[35:32]), .dq_o(dq_o),
      .parity_bus_o(par_o), .dq_oe_o(dq_oe_o), .mem_req_o(req), .mem_rdata_i(rd));
   sbsp_array_model sbsp_array_model_i (.clk_i(clk_i), .req_i(req), .rdata_o(rd));
   task automatic cmp_data(input logic [35:0] g, input logic [35:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp_data
   task automatic cmp_req(input logic [23:0] g, input logic [23:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp_req
   task automatic close_out();
      if (miscompares == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out
   // one bus cycle held for a whole clock n = {check, addr known, lanes, addr}
   task automatic step(input logic [3:0] c, input logic [4:0] w, input logic [2:0] ce,
         input logic [25:0] n, input logic p);
      logic [35:0] d;
      d = 36'({$urandom(), $urandom()});
      @(posedge clk_i);
      bus_i <= sbsp_pkg::sbsp_bus_t'({c[3:1], w, c[0], ce, n[19:0]});
      wd <= d;
      nx <= n;
      for (int i = 0; i < 4; i++) begin
         if (n[20+i]) begin
            sh[n[19:0]][8*i+:8] = d[8*i+:8];
            sh[n[19:0]][32+i] = d[32+i];
         end
      end
      if (p) begin
         exp_q.push_back(sh[n[19:0]]);
      end
   endtask : step
   // requests show one edge after they are taken; pins drive only for noted beats
   always @(posedge clk_i) cur <= nx;
   always @(negedge clk_i) begin
      if (cur[25]) cmp_req({req.lane_we, cur[24] ? req.addr : 20'h0}, {cur[23:20], cur[24] ? cur[19:0] : 20'h0});
      if (dq_oe_o === 1'b1) cmp_data({par_o, dq_o}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      miscompares++;
      close_out();
   end
   initial begin
      bus_i = sbsp_pkg::sbsp_bus_t'({3'h7, 5'h1f, 1'b1, 3'h0, 20'h0});
      hi = 20'($urandom(21720)) & 20'hffff0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      // global write burst seeded at low bits 3, wraps to 0
      step(4'ha, 5'h1f, 3'h2, {2'h3, 4'hf, hi | 20'h3}, 1'b0);
      for (int k = 0; k < 3; k++) step(4'hc, 5'h1f, 3'h2, {2'h3, 4'hf, hi | k[19:0]}, 1'b0);
      step(4'hb, 5'h1f, 3'h0, 26'h0, 1'b0);
      // lane b only, byte enable and select low together
      step(4'hb, 5'h0b, 3'h2, {2'h3, 4'h2, hi}, 1'b0);
      // byte write on a burst beat: lane d only
      step(4'hd, 5'h0e, 3'h2, {2'h3, 4'h8, hi | 20'h1}, 1'b0);
      step(4'hb, 5'h1f, 3'h0, 26'h0, 1'b0);
      // read burst after deselect: first beat kept off the pins
      step(4'hb, 5'h1f, 3'h2, {2'h3, 4'h0, hi | 20'h3}, 1'b0);
      for (int k = 0; k < 3; k++) step(4'hd, 5'h1f, 3'h2, {2'h3, 4'h0, hi | k[19:0]}, 1'b1);
      step(4'h7, 5'h1f, 3'h4, {2'h3, 4'h0, hi | 20'h2}, 1'b1);
      step(4'hd, 5'h1f, 3'h0, {2'h3, 4'h0, hi | 20'h3}, 1'b1);
      step(4'hb, 5'h1f, 3'h0, 26'h0, 1'b0);
      // both strobes with global write low: processor read wins
      step(4'h2, 5'h1f, 3'h2, {2'h3, 4'h0, hi | 20'h1}, 1'b0);
      step(4'hb, 5'h10, 3'h2, {2'h3, 4'h0, hi | 20'h2}, 1'b1);
      step(4'hd, 5'h1f, 3'h2, {2'h3, 4'h0, hi | 20'h3}, 1'b1);
      // every enable combination; only one selects
      for (int i = 0; i < 8; i++) begin
         step(4'ha, 5'h1f, i[2:0], {1'b1, i == 2, (i == 2) ? 4'hf : 4'h0, hi + 20'(i + 4)}, 1'b0);
      end
      step(4'hb, 5'h1f, 3'h0, 26'h0, 1'b0);
      // output enable high keeps pins released even for a live read
      oe_n <= 1'b1;
      repeat (5) @(posedge clk_i);
      step(4'hb, 5'h1f, 3'h2, {2'h3, 4'h0, hi}, 1'b0);
      step(4'hd, 5'h1f, 3'h2, {2'h3, 4'h0, hi | 20'h1}, 1'b0);
      step(4'hb, 5'h1f, 3'h0, 26'h0, 1'b0);
      for (int k = 0; k < 4; k++) begin
         @(negedge clk_i);
         cmp_req({23'h0, dq_oe_o}, 24'h0);
      end
      if (exp_q.size() != 0) miscompares++;
      close_out();
   end
endmodule : sbsp_port_test
